//--- hw/tpgc_timer.sv
// Purpose: 16-bit timer channel with pulse output and pulse width capture.
// Assumes: Pins are synchronous to clk_i; software follows the setup orders.
// Notes: Counter, pin samples and captures change on ticks from the internal prescaler; bus writes act on any clock.
`timescale 1ns/1ns
module tpgc_timer (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timer pins.
  input wire logic primary_capture_pin_i,
  input wire logic secondary_capture_pin_i,
  output logic timer_output_pin_o,
  // Interrupt.
  output logic irq_o
);

  // Merges a bus write into a 16-bit register, honouring the two low byte lanes.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0])
    begin
      merge16[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      merge16[15:8] = dat[15:8];
    end
  endfunction

  // Decides whether a filtered edge matches a two-bit edge selection.
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      tpgc_pkg::TPGC_EDGE_FALL: edge_hit = fall;
      tpgc_pkg::TPGC_EDGE_RISE: edge_hit = rise;
      tpgc_pkg::TPGC_EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  tpgc_pkg::tpgc_mode_t mode_control_reg;
  logic [2:0] capcmp_control_reg;
  logic [15:0] period_compare_reg;
  logic [15:0] width_compare_reg;
  logic [7:0] output_control_reg;
  logic [7:0] prescaler_edge_reg;
  logic [15:0] up_counter;
  tpgc_pkg::tpgc_irq_t irq_status;
  tpgc_pkg::tpgc_irq_t irq_mask;
  logic [6:0] div_cnt;
  logic [1:0] pin_samp;
  logic [1:0] pin_level;
  logic out_level;
  logic ack;
  logic [31:0] rd_data;

  // Bus decode; a write lands on the edge where the master sees ack.
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & ack;
  wire wr_mode = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_MODE);
  wire wr_capcmp = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_CAPCMP);
  wire wr_period = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_PERIOD);
  wire wr_width = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_WIDTH);
  wire wr_outctl = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_OUTCTL);
  wire wr_presc = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_PRESC);
  wire wr_status = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_STATUS);
  wire wr_mask = bus_wr && (wb_adr_i == tpgc_pkg::TPGC_OFF_MASK);

  // Read selection; unmapped offsets answer with zero.
  logic [31:0] rd_sel;
  always_comb
  begin
    case (wb_adr_i)
      tpgc_pkg::TPGC_OFF_MODE: rd_sel = {30'h0, mode_control_reg};
      tpgc_pkg::TPGC_OFF_CAPCMP: rd_sel = {29'h0, capcmp_control_reg};
      tpgc_pkg::TPGC_OFF_PERIOD: rd_sel = {16'h0, period_compare_reg};
      tpgc_pkg::TPGC_OFF_WIDTH: rd_sel = {16'h0, width_compare_reg};
      tpgc_pkg::TPGC_OFF_OUTCTL: rd_sel = {24'h0, output_control_reg};
      tpgc_pkg::TPGC_OFF_PRESC: rd_sel = {24'h0, prescaler_edge_reg};
      tpgc_pkg::TPGC_OFF_COUNT: rd_sel = {16'h0, up_counter};
      tpgc_pkg::TPGC_OFF_STATUS: rd_sel = {29'h0, irq_status};
      tpgc_pkg::TPGC_OFF_MASK: rd_sel = {29'h0, irq_mask};
      default: rd_sel = 32'h0;
    endcase
  end

  // Field views of the control registers.
  wire running = (mode_control_reg != tpgc_pkg::TPGC_MODE_STOP);
  wire pulse_mode = (mode_control_reg == tpgc_pkg::TPGC_MODE_CLEAR);
  wire free_mode = (mode_control_reg == tpgc_pkg::TPGC_MODE_FREE);
  wire [1:0] clk_sel = prescaler_edge_reg[tpgc_pkg::TPGC_PR_CLK_LO +: 2];
  wire [1:0] prim_sel = prescaler_edge_reg[tpgc_pkg::TPGC_PR_PRIM_LO +: 2];
  wire [1:0] sec_sel = prescaler_edge_reg[tpgc_pkg::TPGC_PR_SEC_LO +: 2];
  wire toggle_en = output_control_reg[tpgc_pkg::TPGC_OC_TOGGLE];
  wire out_en = output_control_reg[tpgc_pkg::TPGC_OC_OUT_EN];

  // Count clock; the reserved selection falls back to the full rate.
  wire [6:0] div_ratio = (clk_sel == tpgc_pkg::TPGC_CLK_DIV16) ? tpgc_pkg::TPGC_DIV16_COUNT :
                         (clk_sel == tpgc_pkg::TPGC_CLK_DIV64) ? tpgc_pkg::TPGC_DIV64_COUNT :
                         tpgc_pkg::TPGC_DIV1_COUNT;
  wire [6:0] div_last = div_ratio - 7'h01;
  wire tick = running && (div_cnt == div_last);

  // Noise filter: a level is taken only when two tick samples agree.
  wire [1:0] pin_now = {secondary_capture_pin_i, primary_capture_pin_i};
  wire [1:0] pin_stable = pin_now & pin_samp | ~pin_now & ~pin_samp;
  wire [1:0] pin_rise = {2{tick}} & pin_stable & pin_now & ~pin_level;
  wire [1:0] pin_fall = {2{tick}} & pin_stable & ~pin_now & pin_level;

  // Capture triggers, only in free-running measurement.
  wire prim_hit = edge_hit(prim_sel, pin_rise[0], pin_fall[0]);
  wire prim_inv_hit = edge_hit(prim_sel, pin_fall[0], pin_rise[0]);
  wire sec_hit = edge_hit(sec_sel, pin_rise[1], pin_fall[1]);
  wire cap_width = free_mode && capcmp_control_reg[tpgc_pkg::TPGC_CC_WIDTH_CAP] && prim_hit;
  wire per_cap_on = free_mode && capcmp_control_reg[tpgc_pkg::TPGC_CC_PERIOD_CAP];
  wire per_inv = capcmp_control_reg[tpgc_pkg::TPGC_CC_PERIOD_INV];
  wire cap_sec = per_cap_on && !per_inv && sec_hit;
  wire cap_inv = per_cap_on && per_inv && prim_inv_hit;
  wire cap_period = cap_sec | cap_inv;

  // Compare matches in clear-on-match mode; overflow in any running mode.
  wire period_match = pulse_mode && tick && (up_counter == period_compare_reg);
  wire width_match = pulse_mode && tick && (up_counter == width_compare_reg);
  wire overflow = tick && (up_counter == tpgc_pkg::TPGC_CNT_MAX);

  // Events; the opposite-edge capture raises no interrupt of its own.
  tpgc_pkg::tpgc_irq_t irq_set;
  assign irq_set = {overflow, width_match | cap_width, period_match | cap_sec};
  wire [2:0] irq_clr = wr_status && wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;

  // Bus slave: one wait state, ack is dropped in the cycle after it was given.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      rd_data <= 32'h0;
    end
    else
    begin
      ack <= bus_req & ~ack;
      rd_data <= rd_sel;
    end
  end
  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;

  // Control registers written by software.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_control_reg <= tpgc_pkg::TPGC_MODE_STOP;
      capcmp_control_reg <= tpgc_pkg::TPGC_RST_REG3;
      output_control_reg <= tpgc_pkg::TPGC_RST_REG8;
      prescaler_edge_reg <= tpgc_pkg::TPGC_RST_REG8;
      irq_mask <= tpgc_pkg::TPGC_RST_REG3;
    end
    else
    begin
      if (wr_mode && wb_sel_i[0])
      begin
        mode_control_reg <= tpgc_pkg::tpgc_mode_t'(wb_dat_i[1:0]);
      end
      if (wr_capcmp && wb_sel_i[0])
      begin
        capcmp_control_reg <= wb_dat_i[2:0];
      end
      if (wr_outctl && wb_sel_i[0])
      begin
        output_control_reg <= wb_dat_i[7:0];
      end
      if (wr_presc && wb_sel_i[0])
      begin
        prescaler_edge_reg <= wb_dat_i[7:0];
      end
      if (wr_mask && wb_sel_i[0])
      begin
        irq_mask <= wb_dat_i[2:0];
      end
    end
  end

  // Compare registers double as capture registers; a capture beats a write
  // in the same cycle so a measured edge is never lost.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      period_compare_reg <= tpgc_pkg::TPGC_RST_REG16;
      width_compare_reg <= tpgc_pkg::TPGC_RST_REG16;
    end
    else
    begin
      if (cap_period)
      begin
        period_compare_reg <= up_counter;
      end
      else if (wr_period)
      begin
        period_compare_reg <= merge16(period_compare_reg, wb_dat_i, wb_sel_i);
      end
      if (cap_width)
      begin
        width_compare_reg <= up_counter;
      end
      else if (wr_width)
      begin
        width_compare_reg <= merge16(width_compare_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Prescaler and counter; stopping holds both at zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !running)
    begin
      div_cnt <= 7'h00;
      up_counter <= tpgc_pkg::TPGC_RST_REG16;
    end
    else
    begin
      div_cnt <= tick ? 7'h00 : div_cnt + 7'h01;
      if (period_match)
      begin
        up_counter <= 16'h0000;
      end
      else if (tick)
      begin
        up_counter <= up_counter + 16'h0001;
      end
    end
  end

  // Pin samples and accepted levels; a high pin after reset reads as a rise.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_samp <= 2'h0;
      pin_level <= 2'h0;
    end
    else if (tick)
    begin
      pin_samp <= pin_now;
      pin_level <= (pin_level & ~pin_stable) | (pin_now & pin_stable);
    end
  end

  // Output level: it idles active so a start begins a period high; the width
  // match drops it and the period match raises it again.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pulse_mode)
    begin
      out_level <= 1'b1;
    end
    else if (period_match)
    begin
      out_level <= 1'b1;
    end
    else if (width_match && toggle_en)
    begin
      out_level <= 1'b0;
    end
  end
  assign timer_output_pin_o = out_en & pulse_mode & out_level;

  // Sticky status, write one to clear, a new event beats the clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= tpgc_pkg::TPGC_RST_REG3;
    end
    else
    begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end
  assign irq_o = |(irq_status & irq_mask);

  // Checker copy of the primary pin at the previous tick, kept apart from the filter
  // so that a broken filter cannot vouch for itself.
  logic prim_last_tick;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prim_last_tick <= 1'b0;
    end
    else if (tick)
    begin
      prim_last_tick <= primary_capture_pin_i;
    end
  end

  // Checks next to the logic they guard.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_period_start;
    pulse_mode && tick && (up_counter == period_compare_reg);
  endsequence

  sequence s_width_end;
    pulse_mode && tick && toggle_en && (up_counter == width_compare_reg) &&
      (up_counter != period_compare_reg);
  endsequence

  AST_PERIOD_CLEAR: assert property (s_period_start |=> up_counter == 16'h0000 && irq_status.period)
    else $error("Period match did not clear counter and flag.");
  AST_OUT_RISE: assert property (s_period_start ##1
                                 (mode_control_reg == $past(mode_control_reg)) |-> out_level)
    else $error("Output not active at period start.");
  AST_OUT_FALL: assert property (s_width_end ##1
                                 (mode_control_reg == $past(mode_control_reg)) |-> !out_level)
    else $error("Output did not drop after width match.");
  AST_PIN_START: assert property ($rose(pulse_mode) && out_en |-> timer_output_pin_o)
    else $error("Output not active when pulse output starts.");
  AST_OVF_HOLD: assert property (irq_status.ovf && !irq_clr[2] |=> irq_status.ovf)
    else $error("Overflow flag cleared without software.");
  AST_FILTER: assert property ((pin_rise[0] || pin_fall[0]) |->
                               primary_capture_pin_i == prim_last_tick)
    else $error("Edge accepted without two samples.");
  AST_CAP_PRIM: assert property (cap_width |=> width_compare_reg == $past(up_counter) &&
                                 irq_status.width)
    else $error("Primary capture missing.");
  AST_CAP_SEC: assert property (cap_sec |=> period_compare_reg == $past(up_counter) &&
                                irq_status.period)
    else $error("Secondary capture missing.");
  AST_CAP_INV: assert property (cap_inv |=> period_compare_reg == $past(up_counter))
    else $error("Opposite edge capture missing.");
  AST_EDGE_NONE: assert property (prim_sel == tpgc_pkg::TPGC_EDGE_NONE |-> !prim_hit)
    else $error("Prohibited edge code triggered a capture.");
  AST_STABLE: assert property (pin_rise[1] |-> pin_samp[1] && secondary_capture_pin_i)
    else $error("Secondary edge taken from a single sample.");

endmodule

//--- pkg/tpgc_pkg.sv
// Purpose: Shared constants and types for the pulse generator and capture timer.
// Assumes: One 250 MHz clock, classic Wishbone register access with 32-bit data.
// Notes: Every offset, field position, reset value and divider count lives here.
//
// Overview of operation
// - Pulse mode drives a rectangular wave on output pin.
// - Period lasts period+1 ticks, high lasts width+1.
// - Pins sampled per tick; two equal samples accept level.
// - Overflow flag stays set until software clears it.
// - Primary edge copies count into width register, interrupt.
// - Secondary edge copies count into period register, interrupt.
// - Opposite primary edge captures into period register.
// - Edge select: 00 fall, 01 rise, 10 none, 11 both.
// - Period match clears counter and raises period interrupt.
package tpgc_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] TPGC_OFF_MODE = 8'h00;
  localparam logic [7:0] TPGC_OFF_CAPCMP = 8'h04;
  localparam logic [7:0] TPGC_OFF_PERIOD = 8'h08;
  localparam logic [7:0] TPGC_OFF_WIDTH = 8'h0C;
  localparam logic [7:0] TPGC_OFF_OUTCTL = 8'h10;
  localparam logic [7:0] TPGC_OFF_PRESC = 8'h14;
  localparam logic [7:0] TPGC_OFF_COUNT = 8'h18;
  localparam logic [7:0] TPGC_OFF_STATUS = 8'h1C;
  localparam logic [7:0] TPGC_OFF_MASK = 8'h20;

  // Field positions inside the control registers.
  localparam int TPGC_CC_PERIOD_CAP = 0;
  localparam int TPGC_CC_PERIOD_INV = 1;
  localparam int TPGC_CC_WIDTH_CAP = 2;
  localparam int TPGC_OC_OUT_EN = 0;
  localparam int TPGC_OC_TOGGLE = 4;
  localparam int TPGC_PR_CLK_LO = 0;
  localparam int TPGC_PR_PRIM_LO = 4;
  localparam int TPGC_PR_SEC_LO = 6;

  // Reset values and the counter maximum.
  localparam logic [15:0] TPGC_RST_REG16 = 16'h0000;
  localparam logic [7:0] TPGC_RST_REG8 = 8'h00;
  localparam logic [2:0] TPGC_RST_REG3 = 3'h0;
  localparam logic [15:0] TPGC_CNT_MAX = 16'hFFFF;

  // Count clock selection and the divide ratio of each choice.
  localparam logic [1:0] TPGC_CLK_DIV1 = 2'h0;
  localparam logic [1:0] TPGC_CLK_DIV16 = 2'h1;
  localparam logic [1:0] TPGC_CLK_DIV64 = 2'h2;
  localparam logic [6:0] TPGC_DIV1_COUNT = 7'h01;
  localparam logic [6:0] TPGC_DIV16_COUNT = 7'h10;
  localparam logic [6:0] TPGC_DIV64_COUNT = 7'h40;

  // Edge selection codes.
  localparam logic [1:0] TPGC_EDGE_FALL = 2'h0;
  localparam logic [1:0] TPGC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TPGC_EDGE_NONE = 2'h2;
  localparam logic [1:0] TPGC_EDGE_BOTH = 2'h3;

  // Operating modes of the counter.
  typedef enum logic [1:0] {
    TPGC_MODE_STOP = 2'b00,
    TPGC_MODE_FREE = 2'b01,
    TPGC_MODE_CLEAR = 2'b10
  } tpgc_mode_t;

  // Interrupt status and mask layout.
  typedef struct packed {
    logic ovf;
    logic width;
    logic period;
  } tpgc_irq_t;

endpackage

//--- verification/tpgc_pin_model.sv
// Purpose: Pin-side partner that holds pulse sources on the capture pins and a load on the output.
// Assumes: Sources change just after a rising clock edge, like the logic that feeds them.
// Notes: The load measures the high time and the period of the output in clock cycles.
`timescale 1ns/1ns
module tpgc_pin_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Source requests from the bench.
  input wire logic prim_req_i,
  input wire logic sec_req_i,
  // Timer pins.
  input wire logic load_pin_i,
  output logic primary_pin_o,
  output logic secondary_pin_o,
  // Measured shape of the output.
  output logic [15:0] high_len_o,
  output logic [15:0] period_len_o
);
  logic prev_load;
  logic [15:0] since_rise;

  // Both pins are always driven as sources, so neither floats to an unknown level.
  always_ff @(posedge clk_i)
  begin
    primary_pin_o <= prim_req_i;
    secondary_pin_o <= sec_req_i;
  end

  // Cycles are counted from each rise; a fall latches the high time, a rise the period.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_load <= 1'b0;
      since_rise <= 16'h0000;
      high_len_o <= 16'h0000;
      period_len_o <= 16'h0000;
    end
    else
    begin
      prev_load <= load_pin_i;
      since_rise <= (load_pin_i && !prev_load) ? 16'h0001 : since_rise + 16'h0001;
      if (load_pin_i && !prev_load)
        period_len_o <= since_rise;
      if (!load_pin_i && prev_load)
        high_len_o <= since_rise;
    end
  end
endmodule

//--- verification/testbench.sv
// Purpose: Self-checking bench for the pulse output and capture timer channel.
// Assumes: Wishbone acks one cycle after a request; prescaler ratio 1 throughout.
// Notes: The overflow scenario lets the counter wrap once, about 66000 cycles.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic prim_req = 1'b0;
  logic sec_req = 1'b0;
  logic [31:0] dat_o;
  logic ack;
  logic prim_pin;
  logic sec_pin;
  logic out_pin;
  logic irq;
  logic [15:0] high_len;
  logic [15:0] period_len;
  logic [31:0] rv;
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] pv [2] = '{32'h0000_0005, 32'h0000_0003};
  logic [31:0] wv [2] = '{32'h0000_0002, 32'h0000_0000};
  logic [7:0] ra [6] = '{8'h00, 8'h18, 8'h1C, 8'h20, 8'h08, 8'h3C};
  int num_errors = 0;
  int tests_run = 0;

  // The clock runs at 250 MHz.
  initial
  begin
    forever #2 clk = ~clk;
  end

  tpgc_timer i_tpgc_timer (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .primary_capture_pin_i(prim_pin), .secondary_capture_pin_i(sec_pin),
    .timer_output_pin_o(out_pin), .irq_o(irq));

  tpgc_pin_model i_tpgc_pin_model (.clk_i(clk), .rst_i(rst), .prim_req_i(prim_req),
    .sec_req_i(sec_req), .load_pin_i(out_pin), .primary_pin_o(prim_pin),
    .secondary_pin_o(sec_pin), .high_len_o(high_len), .period_len_o(period_len));

  task automatic final_report;
    begin
      if (num_errors == 0 && tests_run > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  // One classic cycle; ack and read data are taken at the same rising edge, and the
  // request is held until then, then dropped for a full cycle before the next one.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50)
      begin
        @(posedge clk);
        n++;
      end
      if (n >= 50)
        num_errors++;
      rv = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      wb(1'b1, a, d);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    begin
      wb(1'b0, a, 32'h0000_0000);
    end
  endtask

  task automatic idle(input int n);
    begin
      repeat (n) @(posedge clk);
    end
  endtask

  // A hang is cut short well after the roughly 70000 cycles the tests need.
  initial
  begin
    #360000;
    num_errors++;
    final_report();
  end

  initial
  begin
    idle(16);
    rst <= 1'b0;
    @(posedge clk);
    foreach (ra[i])
    begin
      rd(ra[i]);
      chk("reset_value", rv, 32'h0000_0000);
    end
    // Pulse output at two shapes, the second with the smallest width.
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h08, pv[i]);
      wr(8'h0C, wv[i]);
      wr(8'h10, 32'h11);
      wr(8'h14, 32'h0);
      wr(8'h20, 32'h1);
      wr(8'h00, 32'h2);
      idle(40);
      chk("high_len", 32'(high_len), wv[i] + 32'h1);
      chk("period_len", 32'(period_len), pv[i] + 32'h1);
      rd(8'h18);
      chk("count_bound", 32'(rv <= pv[i]), 32'h1);
      rd(8'h1C);
      chk("period_flag", 32'(rv[0]), 32'h1);
      chk("irq_on", 32'(irq), 32'h1);
    end
    // Width change while counting, in the safe order.
    wr(8'h10, 32'h01);
    wr(8'h20, 32'h1);
    wr(8'h0C, 32'h1);
    idle(1);
    wr(8'h10, 32'h11);
    wr(8'h1C, 32'h2);
    wr(8'h20, 32'h3);
    idle(40);
    chk("new_high_len", 32'(high_len), 32'h2);
    chk("new_period_len", 32'(period_len), 32'h4);
    wr(8'h20, 32'h0);
    chk("irq_masked", 32'(irq), 32'h0);
    // Every edge code, one rise and one fall each.
    wr(8'h04, 32'h4);
    for (int e = 0; e < 4; e++)
    begin
      wr(8'h00, 32'h0);
      wr(8'h14, 32'(e) << 4);
      wr(8'h00, 32'h1);
      wr(8'h1C, 32'h7);
      prim_req <= 1'b1;
      idle(8);
      rd(8'h1C);
      chk("rise_capture", 32'(rv[1]), 32'(e % 2));
      wr(8'h1C, 32'h7);
      prim_req <= 1'b0;
      idle(8);
      rd(8'h1C);
      chk("fall_capture", 32'(rv[1]), 32'(e == 0 || e == 3));
    end
    // A pin pulse of one tick is noise; a held level captures the running count.
    wr(8'h1C, 32'h7);
    prim_req <= 1'b1;
    @(posedge clk);
    prim_req <= 1'b0;
    idle(8);
    rd(8'h1C);
    chk("glitch", 32'(rv[1]), 32'h0);
    rd(8'h18);
    lo = rv;
    prim_req <= 1'b1;
    idle(8);
    rd(8'h18);
    hi = rv;
    rd(8'h0C);
    chk("width_capture", 32'(rv >= lo && rv <= hi), 32'h1);
    rd(8'h1C);
    chk("width_flag", 32'(rv[1]), 32'h1);
    prim_req <= 1'b0;
    idle(8);
    // Two pins, both edges selected on each; only the rises are checked.
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h5);
    wr(8'h14, 32'hF0);
    wr(8'h00, 32'h1);
    wr(8'h1C, 32'h7);
    sec_req <= 1'b1;
    idle(8);
    rd(8'h1C);
    chk("secondary_flag", 32'(rv[1:0]), 32'h1);
    prim_req <= 1'b1;
    idle(8);
    rd(8'h1C);
    chk("both_flags", 32'(rv[1:0]), 32'h3);
    prim_req <= 1'b0;
    sec_req <= 1'b0;
    idle(8);
    // One pin into two registers, rising edge selected.
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h7);
    wr(8'h14, 32'h10);
    wr(8'h00, 32'h1);
    wr(8'h1C, 32'h7);
    prim_req <= 1'b1;
    idle(8);
    rd(8'h1C);
    chk("selected_edge", 32'(rv[1:0]), 32'h2);
    wr(8'h1C, 32'h7);
    rd(8'h18);
    lo = rv;
    prim_req <= 1'b0;
    idle(8);
    rd(8'h18);
    hi = rv;
    rd(8'h08);
    chk("opposite_capture", 32'(rv >= lo && rv <= hi), 32'h1);
    rd(8'h1C);
    chk("opposite_no_irq", 32'(rv[1:0]), 32'h0);
    // The overflow flag stays until software clears it.
    wr(8'h1C, 32'h7);
    idle(66000);
    rd(8'h1C);
    chk("overflow_set", 32'(rv[2]), 32'h1);
    idle(2000);
    rd(8'h1C);
    chk("overflow_held", 32'(rv[2]), 32'h1);
    wr(8'h20, 32'h4);
    chk("irq_overflow", 32'(irq), 32'h1);
    wr(8'h1C, 32'h4);
    rd(8'h1C);
    chk("overflow_clear", 32'(rv[2]), 32'h0);
    chk("irq_cleared", 32'(irq), 32'h0);
    final_report();
  end
endmodule
